// ---- design/ethm_pkg.sv ----
// Shared constants, field positions and state encodings of the MAC framing block
package ethm_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_TCTL   = 8'h00;
  localparam logic [7:0]  OFS_RCTL   = 8'h04;
  localparam logic [7:0]  OFS_RIS    = 8'h08;
  localparam logic [7:0]  OFS_TXD    = 8'h0C;
  localparam logic [7:0]  OFS_RXD    = 8'h10;
  localparam logic [7:0]  OFS_RXCNT  = 8'h14;
  localparam logic [7:0]  OFS_LED    = 8'h18;
  localparam logic [7:0]  OFS_RXLT   = 8'h1C;

  // Field positions
  localparam int TCTL_START_BIT = 0;
  localparam int TCTL_PAD_BIT   = 1;
  localparam int TCTL_CRC_BIT   = 2;
  localparam int RCTL_EN_BIT    = 0;
  localparam int RCTL_BAD_BIT   = 1;
  localparam int RIS_FOV_BIT    = 0;
  localparam int RIS_RXERR_BIT  = 1;
  localparam int LED_ALT_FUNCTION_SELECT_LSB  = 0;
  localparam int LED_GPIO_LSB   = 2;
  localparam int RXLT_TYPE_BIT  = 16;
  localparam int RXLT_GRP_BIT   = 17;

  // Reset values
  localparam logic       PAD_EN_RST  = 1'h1;
  localparam logic       CRC_INS_RST = 1'h1;
  localparam logic       RX_EN_RST   = 1'h0;
  localparam logic       BAD_REJ_RST = 1'h1;
  localparam logic [1:0] ALT_FUNCTION_SELECT_RST   = 2'h0;
  localparam logic [1:0] GPIO_RST    = 2'h0;

  // Frame layout
  localparam logic [7:0]  PRE_BYTE    = 8'h55;
  localparam logic [2:0]  PRE_LEN     = 3'h7;
  localparam logic [7:0]  SFD_BYTE    = 8'hD5;
  localparam logic [16:0] HDR_BYTES   = 17'h0_0010;
  localparam logic [16:0] FCS_BYTES   = 17'h0_0004;
  localparam logic [16:0] DA_POS      = 17'h0_0002;
  localparam logic [15:0] PAD_MIN     = 16'h002E;
  localparam logic [15:0] LT_MAX      = 16'h05DC;
  localparam logic [11:0] LT_HI_IDX   = 12'h00C;
  localparam logic [11:0] LT_LO_IDX   = 12'h00D;
  localparam int          BUF_WORDS   = 512;
  localparam logic [9:0]  BUF_SPACE   = 10'h200;
  localparam logic [4:0]  MAX_FRAMES  = 5'h1F;

  // Check sequence
  localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;

  // State encodings
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE  = 2'b01,
    TX_DATA = 2'b11,
    TX_FCS  = 2'b10
  } ethm_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_PRE  = 2'b01,
    RX_DATA = 2'b11,
    RX_DROP = 2'b10
  } ethm_rx_st_t;

endpackage

// ---- design/ethm_crc_nib.sv ----
// Nibble-wide CRC-32 engine, instantiated once for the transmit path and once for the receive path
`timescale 1ns/1ps
module ethm_crc_nib
  import ethm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Control and data
  input  wire logic        i_init,
  input  wire logic        i_step,
  input  wire logic [3:0]  i_nib,
  // Running check value
  output logic      [31:0] o_crc
);

  typedef struct packed {
    logic [31:0] crc;
  } ethm_crc_state_t;

  ethm_crc_state_t s;
  ethm_crc_state_t n;
  logic [31:0]     c;

  always_comb begin
    c = s.crc;
    for (int b = 0; b < 4; b++) begin
      c = (c >> 1) ^ ((c[0] ^ i_nib[b]) ? CRC_POLY : 32'h0000_0000); // [RQ15]
    end
    n = s;
    if (i_init) begin
      n.crc = CRC_INIT;
    end else if (i_step) begin
      n.crc = c; // [RQ15]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_crc = s.crc;

endmodule

// ---- design/ethm_mac.sv ----
// MAC framing block: transmit serialiser, receive parser, buffers and registers
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// [RQ1] Transmit opens with seven preamble octets; receive uses preamble only for lock.
// [RQ2] Start delimiter 1010.1011 follows preamble; receiver starts frame content after it.
// [RQ3] Fields go out preamble, delimiter, DA, SA, Length/Type, data, check sequence.
// [RQ4] Each field is shifted out least significant bit first.
// [RQ5] Destination bit zero marks group address; buffer word zero bit 16.
// [RQ6] Length/Type up to 1500 reads as a data octet count.
// [RQ7] Length/Type above 1500 reads as a type code.
// [RQ8] Length/Type first octet is the most significant one.
// [RQ9] Payload octets pass untouched with no reserved codes.
// [RQ10] Payload under 46 octets is padded up to 46.
// [RQ11] With pad enable cleared short payloads go out unpadded.
// [RQ12] No frame-too-long error beyond 1500 data octets.
// [RQ13] Frame too big for the 2K receive buffer sets the overrun flag.
// [RQ14] CRC-32 covers DA, SA, Length/Type and data with pad.
// [RQ15] The CRC advances one nibble per step.
// [RQ16] Check sequence appended on transmit unless CRC insert is cleared.
// [RQ17] Bad check sequence frames dropped unless bad-CRC reject is cleared.
// [RQ18] CPU reaches the block by registers; frames use the internal MII.
// [RQ19] Indicator pins act as GPIO after reset until selected.
// [RQ20] Rejected bad frame raises receive error and its data is lost.
// [RQ21] Receive buffer holds at most 31 whole frames.
// [RQ22] Preamble and delimiter never enter the buffers.
// [RQ23] Padding decision measures the data field alone.
module ethm_mac
  import ethm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // MII transmit
  input  wire logic        i_mii_tx_clk,
  output logic      [3:0]  o_mii_txd,
  output logic             o_mii_tx_en,
  // MII receive
  input  wire logic        i_mii_rx_clk,
  input  wire logic        i_mii_rx_dv,
  input  wire logic [3:0]  i_mii_rxd,
  // Activity indicators
  output logic             o_activity_indicator_a,
  output logic             o_activity_indicator_b
);

  typedef struct packed {
    logic [2:0]                  txc;
    logic [2:0]                  rxc;
    logic [1:0]                  dv;
    logic [7:0]                  rxd;
    logic                        pad_en;
    logic                        crc_ins;
    logic                        tx_go;
    logic                        rx_en;
    logic                        bad_rej;
    logic                        rx_fifo_overrun_flag;
    logic                        rxerr;
    logic [1:0]                  alt_function_select;
    logic [1:0]                  gpio;
    logic                        led_a;
    logic                        led_b;
    logic [BUF_WORDS-1:0][31:0]  txbuf;
    logic [8:0]                  twidx;
    ethm_tx_st_t                 tx_st;
    logic [16:0]                 tidx;
    logic                        thalf;
    logic [3:0]                  pcnt;
    logic [2:0]                  fcnt;
    logic [3:0]                  txd;
    logic                        txen;
    logic [BUF_WORDS-1:0][31:0]  rxbuf;
    logic [8:0]                  rfptr;
    logic [8:0]                  rrptr;
    logic [9:0]                  used;
    logic [4:0]                  frames;
    ethm_rx_st_t                 rx_st;
    logic [3:0]                  rlo;
    logic                        rhalf;
    logic [11:0]                 rbcnt;
    logic [15:0]                 rlt;
    logic                        rgrp;
    logic [15:0]                 lt_last;
    logic                        grp_last;
    logic [31:0]                 rdata;
  } ethm_state_t;

  ethm_state_t s;
  ethm_state_t n;

  logic        tx_fall;
  logic        rx_rise;
  logic        dv;
  logic [3:0]  rxd;
  logic [15:0] t_len;
  logic [15:0] t_dlen;
  logic [16:0] t_end;
  logic [16:0] t_pad_lo;
  logic [16:0] t_pad_hi;
  logic [7:0]  t_byte;
  logic [3:0]  t_nib;
  logic [11:0] r_pos;
  logic [9:0]  r_free;
  logic [9:0]  r_words;
  logic [7:0]  r_byte;
  logic [9:0]  add;
  logic        pop;
  logic        tx_crc_init;
  logic        tx_crc_step;
  logic        rx_crc_init;
  logic        rx_crc_step;
  logic [31:0] tx_crc;
  logic [31:0] rx_crc;

  ethm_crc_nib u_tx_crc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_init  (tx_crc_init),
    .i_step  (tx_crc_step),
    .i_nib   (t_nib),
    .o_crc   (tx_crc)
  );

  ethm_crc_nib u_rx_crc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_init  (rx_crc_init),
    .i_step  (rx_crc_step),
    .i_nib   (rxd),
    .o_crc   (rx_crc)
  );

  always_comb begin
    n           = s;
    add         = 10'h000;
    pop         = 1'b0;
    tx_crc_init = 1'b0;
    tx_crc_step = 1'b0;
    rx_crc_init = 1'b0;
    rx_crc_step = 1'b0;

    // Link pin synchronisers and edge detection
    n.txc   = {s.txc[1:0], i_mii_tx_clk};
    n.rxc   = {s.rxc[1:0], i_mii_rx_clk};
    n.dv    = {s.dv[0], i_mii_rx_dv};
    n.rxd   = {s.rxd[3:0], i_mii_rxd};
    tx_fall = s.txc[2] & ~s.txc[1];
    rx_rise = ~s.rxc[2] & s.rxc[1];
    dv      = s.dv[1];
    rxd     = s.rxd[7:4];

    // Transmit byte fetch and padding
    t_len    = s.txbuf[0][15:0];
    t_dlen   = (s.pad_en && (t_len < PAD_MIN)) ? PAD_MIN : t_len; // [RQ10] [RQ11] [RQ23]
    t_end    = HDR_BYTES + 17'(t_dlen) + (s.crc_ins ? 17'h0_0000 : FCS_BYTES); // [RQ16]
    t_pad_lo = HDR_BYTES + 17'(t_len);
    t_pad_hi = HDR_BYTES + 17'(t_dlen);
    t_byte   = s.txbuf[s.tidx[10:2]][{s.tidx[1:0], 3'b000} +: 8]; // [RQ9]
    if ((s.tidx >= t_pad_lo) && (s.tidx < t_pad_hi)) begin
      t_byte = 8'h00; // [RQ10]
    end
    t_nib = s.thalf ? t_byte[7:4] : t_byte[3:0]; // [RQ4]

    // Receive placement: two header bytes precede the destination address
    r_pos   = s.rbcnt + DA_POS[11:0];
    r_free  = BUF_SPACE - s.used;
    r_words = r_pos[11:2] + {9'h000, |r_pos[1:0]};
    r_byte  = {rxd, s.rlo};

    // Register writes
    if (i_wr) begin
      unique case (i_addr) // [RQ18]
        OFS_TCTL: begin
          n.pad_en  = i_wdata[TCTL_PAD_BIT]; // [RQ11]
          n.crc_ins = i_wdata[TCTL_CRC_BIT]; // [RQ16]
          if (i_wdata[TCTL_START_BIT] && !s.tx_go) begin
            n.tx_go = 1'b1;
          end
        end
        OFS_TXD: begin
          if (!s.tx_go) begin
            n.txbuf[s.twidx] = i_wdata;
            n.twidx          = s.twidx + 9'h001;
          end
        end
        OFS_RCTL: begin
          n.rx_en   = i_wdata[RCTL_EN_BIT];
          n.bad_rej = i_wdata[RCTL_BAD_BIT]; // [RQ17]
        end
        OFS_RIS: begin
          n.rx_fifo_overrun_flag   = s.rx_fifo_overrun_flag & ~i_wdata[RIS_FOV_BIT];
          n.rxerr = s.rxerr & ~i_wdata[RIS_RXERR_BIT];
        end
        OFS_RXCNT: begin
          if (s.frames != 5'h00) begin
            n.frames = s.frames - 5'h01;
          end
        end
        OFS_LED: begin
          n.alt_function_select = i_wdata[LED_ALT_FUNCTION_SELECT_LSB +: 2];
          n.gpio  = i_wdata[LED_GPIO_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Register reads: data stand in the following cycle only
    n.rdata = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr) // [RQ18]
        OFS_TCTL:  n.rdata = {29'h0, s.crc_ins, s.pad_en, s.tx_go};
        OFS_RCTL:  n.rdata = {30'h0, s.bad_rej, s.rx_en};
        OFS_RIS:   n.rdata = {30'h0, s.rxerr, s.rx_fifo_overrun_flag};
        OFS_RXCNT: n.rdata = {27'h0, s.frames};
        OFS_LED:   n.rdata = {28'h0, s.gpio, s.alt_function_select};
        OFS_RXLT: begin
          n.rdata                = {16'h0000, s.lt_last};
          n.rdata[RXLT_TYPE_BIT] = s.lt_last > LT_MAX; // [RQ6] [RQ7]
          n.rdata[RXLT_GRP_BIT]  = s.grp_last; // [RQ5]
        end
        OFS_RXD: begin
          if (s.used != 10'h000) begin
            n.rdata = s.rxbuf[s.rrptr];
            n.rrptr = s.rrptr + 9'h001;
            pop     = 1'b1;
          end
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // Transmit sequencer, one nibble per falling link clock edge
    if (tx_fall) begin
      unique case (s.tx_st) // [RQ3]
        TX_IDLE: begin
          n.txen = 1'b0;
          if (s.tx_go) begin
            n.txen      = 1'b1;
            n.txd       = PRE_BYTE[3:0]; // [RQ1] [RQ22]
            n.pcnt      = 4'h1;
            n.tx_st     = TX_PRE;
            tx_crc_init = 1'b1;
          end
        end
        TX_PRE: begin
          if (s.pcnt[3:1] == PRE_LEN) begin
            n.txd = s.pcnt[0] ? SFD_BYTE[7:4] : SFD_BYTE[3:0]; // [RQ2] [RQ4]
          end else begin
            n.txd = s.pcnt[0] ? PRE_BYTE[7:4] : PRE_BYTE[3:0]; // [RQ1]
          end
          n.pcnt = s.pcnt + 4'h1;
          if (s.pcnt == 4'hF) begin
            n.tx_st = TX_DATA;
            n.tidx  = DA_POS;
            n.thalf = 1'b0;
          end
        end
        TX_DATA: begin
          n.txd       = t_nib; // [RQ4] [RQ8] [RQ9]
          tx_crc_step = 1'b1; // [RQ14]
          n.thalf     = ~s.thalf;
          if (s.thalf) begin
            if ((s.tidx + 17'h0_0001) >= t_end) begin
              n.fcnt = 3'h0;
              if (s.crc_ins) begin
                n.tx_st = TX_FCS; // [RQ16]
              end else begin
                n.tx_st = TX_IDLE;
                n.tx_go = 1'b0;
                n.twidx = 9'h000;
              end
            end else begin
              n.tidx = s.tidx + 17'h0_0001; // [RQ12]
            end
          end
        end
        TX_FCS: begin
          n.txd  = ~tx_crc[{s.fcnt, 2'b00} +: 4]; // [RQ4] [RQ16]
          n.fcnt = s.fcnt + 3'h1;
          if (s.fcnt == 3'h7) begin
            n.tx_st = TX_IDLE;
            n.tx_go = 1'b0;
            n.twidx = 9'h000;
          end
        end
      endcase
    end

    // Receive parser, one nibble per rising link clock edge
    if (rx_rise) begin
      unique case (s.rx_st)
        RX_IDLE: begin
          if (s.rx_en && dv && (rxd == PRE_BYTE[3:0])) begin
            n.rx_st = RX_PRE; // [RQ1]
          end
        end
        RX_PRE: begin
          if (!dv) begin
            n.rx_st = RX_IDLE;
          end else if (rxd == SFD_BYTE[7:4]) begin // [RQ2] [RQ22]
            if (s.frames == MAX_FRAMES) begin
              n.rx_fifo_overrun_flag   = 1'b1; // [RQ21]
              n.rx_st = RX_DROP;
            end else begin
              n.rx_st     = RX_DATA;
              n.rbcnt     = 12'h000;
              n.rhalf     = 1'b0;
              rx_crc_init = 1'b1;
            end
          end
        end
        RX_DATA: begin
          if (!dv) begin
            n.rx_st = RX_IDLE;
            if ((rx_crc != CRC_RESIDUE) && s.bad_rej) begin
              n.rxerr = 1'b1; // [RQ17] [RQ20]
            end else begin
              n.rxbuf[s.rfptr][15:0] = {4'h0, s.rbcnt};
              n.rfptr                = s.rfptr + r_words[8:0];
              add                    = r_words;
              n.frames               = n.frames + 5'h01; // [RQ21]
              n.lt_last              = s.rlt; // [RQ8]
              n.grp_last             = s.rgrp; // [RQ5]
            end
          end else begin
            rx_crc_step = 1'b1; // [RQ14]
            n.rhalf     = ~s.rhalf;
            if (!s.rhalf) begin
              n.rlo = rxd; // [RQ4]
            end else if (r_pos[11] || ({1'b0, r_pos[10:2]} >= r_free)) begin
              n.rx_fifo_overrun_flag   = 1'b1; // [RQ13] [RQ12]
              n.rx_st = RX_DROP;
            end else begin
              n.rxbuf[s.rfptr + r_pos[10:2]][{r_pos[1:0], 3'b000} +: 8] = r_byte; // [RQ9]
              n.rbcnt = s.rbcnt + 12'h001;
              if (s.rbcnt == 12'h000) begin
                n.rgrp = r_byte[0]; // [RQ5]
              end
              if (s.rbcnt == LT_HI_IDX) begin
                n.rlt[15:8] = r_byte; // [RQ8]
              end
              if (s.rbcnt == LT_LO_IDX) begin
                n.rlt[7:0] = r_byte;
              end
            end
          end
        end
        RX_DROP: begin
          if (!dv) begin
            n.rx_st = RX_IDLE;
          end
        end
      endcase
    end

    n.used = s.used + add - {9'h000, pop};

    // Indicator pins: GPIO value until the alternate function is selected
    n.led_a = s.alt_function_select[0] ? s.txen : s.gpio[0]; // [RQ19]
    n.led_b = s.alt_function_select[1] ? (s.rx_st == RX_DATA) : s.gpio[1]; // [RQ19]
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s         <= '0;
      s.pad_en  <= PAD_EN_RST;
      s.crc_ins <= CRC_INS_RST;
      s.rx_en   <= RX_EN_RST;
      s.bad_rej <= BAD_REJ_RST;
      s.alt_function_select   <= ALT_FUNCTION_SELECT_RST;
      s.gpio    <= GPIO_RST;
    end else begin
      s <= n;
    end
  end

  assign o_rdata                = s.rdata;
  assign o_mii_txd              = s.txd;
  assign o_mii_tx_en            = s.txen;
  assign o_activity_indicator_a = s.led_a;
  assign o_activity_indicator_b = s.led_b;

endmodule

// ---- test/ethm_mac_checker.sv ----
// Port-level assertions for the MAC framing block
`timescale 1ns/1ps
module ethm_mac_checker
  import ethm_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  // Link and indicator
  input  wire logic        i_mii_tx_clk,
  input  wire logic [3:0]  o_mii_txd,
  input  wire logic        o_mii_tx_en,
  input  wire logic        o_activity_indicator_a
);
  logic       alt_r;
  logic       gpio_r;
  logic [1:0] wq_r;

  // Shadow of indicator select and settle time after a write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_r  <= 1'b0;
      gpio_r <= 1'b0;
      wq_r   <= 2'h3;
    end else if (i_wr && i_addr == OFS_LED) begin
      alt_r  <= i_wdata[0];
      gpio_r <= i_wdata[2];
      wq_r   <= 2'h0;
    end else if (wq_r != 2'h3) begin
      wq_r   <= wq_r + 2'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property ($past(i_rd) && ($past(i_addr) > OFS_RXLT
    || ($past(i_addr) & 8'h03) != 8'h00) |-> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_preamble_first: assert property ($rose(o_mii_tx_en) |-> (o_mii_txd == 4'h5)[*6])
    else $error("frame does not open with preamble nibbles");
  a_txd_on_fall: assert property ($changed(o_mii_txd) |-> !i_mii_tx_clk)
    else $error("transmit nibble moved while link clock high");
  a_ind_gpio: assert property (wq_r == 2'h3 && !alt_r
    |-> o_activity_indicator_a == gpio_r)
    else $error("indicator does not follow its port value");
  a_ind_alt_tx: assert property (wq_r == 2'h3 && alt_r
    |-> o_activity_indicator_a == o_mii_tx_en || o_activity_indicator_a == $past(o_mii_tx_en))
    else $error("indicator does not follow transmit enable");
  a_status_width: assert property ($past(i_rd) && $past(i_addr) == OFS_RIS
    |-> o_rdata[31:2] == 30'h0)
    else $error("status read has stray bits");
  a_count_width: assert property ($past(i_rd) && $past(i_addr) == OFS_RXCNT
    |-> o_rdata[31:5] == 27'h0)
    else $error("frame count above five bits");
  a_type_bit: assert property ($past(i_rd) && $past(i_addr) == OFS_RXLT
    |-> o_rdata[16] == (o_rdata[15:0] > LT_MAX))
    else $error("type flag disagrees with length field");

  c_tx_frame: cover property ($rose(o_mii_tx_en));
  c_rx_error: cover property ($past(i_rd) && $past(i_addr) == OFS_RIS && o_rdata[1]);
  c_rx_type: cover property ($past(i_rd) && $past(i_addr) == OFS_RXLT && o_rdata[16]);
endmodule

// ---- test/ethm_phy_model.sv ----
// PHY side model: link clocks, transmit capture and receive frame source
`timescale 1ns/1ps
module ethm_phy_model (
  // Transmit side
  input  wire logic [3:0] i_txd,
  input  wire logic       i_tx_en,
  output logic            o_tx_clk,
  // Receive side
  output logic            o_rx_clk,
  output logic            o_rx_dv,
  output logic [3:0]      o_rxd
);
  logic [3:0] txq[$];

  initial begin
    o_tx_clk = 1'b0;
    o_rx_clk = 1'b0;
    o_rx_dv  = 1'b0;
    o_rxd    = 4'hA;
  end
  always #200 o_tx_clk = ~o_tx_clk;
  initial #73 forever #200 o_rx_clk = ~o_rx_clk;

  // Capture every nibble the MAC puts on the link
  always @(posedge o_tx_clk) begin
    if (i_tx_en) begin
      txq.push_back(i_txd);
    end
  end

  // Send preamble, delimiter and bytes low nibble first
  task automatic rx_send(input logic [7:0] f[$]);
    logic [3:0] n[$];
    repeat (15) n.push_back(4'h5);
    n.push_back(4'hD);
    foreach (f[i]) begin
      n.push_back(f[i][3:0]);
      n.push_back(f[i][7:4]);
    end
    foreach (n[i]) begin
      @(negedge o_rx_clk);
      o_rx_dv <= 1'b1;
      o_rxd   <= n[i];
    end
    @(negedge o_rx_clk);
    o_rx_dv <= 1'b0;
    o_rxd   <= ~o_rxd;
  endtask
endmodule

// ---- test/ethm_mac_test.sv ----
// Testbench for the MAC framing block
`timescale 1ns/1ps
module ethm_mac_test;
  import ethm_pkg::*;
  logic        clk, rst_n, wr, rd, tx_en, tx_clk, rx_clk, rx_dv, ind_a, ind_b;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [3:0]  txd, rxd;
  logic [7:0]  f[$], g[$], b[$];
  int          failures, n_checks, cyc;

  ethm_mac i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_mii_tx_clk(tx_clk), .o_mii_txd(txd), .o_mii_tx_en(tx_en),
    .i_mii_rx_clk(rx_clk), .i_mii_rx_dv(rx_dv), .i_mii_rxd(rxd),
    .o_activity_indicator_a(ind_a), .o_activity_indicator_b(ind_b));
  ethm_phy_model i_phy (.i_txd(txd), .i_tx_en(tx_en), .o_tx_clk(tx_clk), .o_rx_clk(rx_clk),
    .o_rx_dv(rx_dv), .o_rxd(rxd));

  always #25 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 r = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rdr(a);
    chk(r, exp);
  endtask

  function automatic logic [31:0] crc32(input logic [7:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic add_fcs(ref logic [7:0] q[$]);
    logic [31:0] c;
    c = crc32(q);
    for (int i = 0; i < 4; i++) q.push_back(c[8*i+:8]);
  endtask

  // Load the transmit buffer, start, and compare the nibbles seen on the link
  task automatic tx_run(input logic [31:0] ctl, input logic [7:0] bq[$], input logic [7:0] ex[$]);
    i_phy.txq.delete();
    while (bq.size() % 4 != 0) bq.push_back(8'h00);
    for (int i = 0; i < bq.size(); i += 4) wrr(OFS_TXD, {bq[i+3], bq[i+2], bq[i+1], bq[i]});
    wrr(OFS_TCTL, ctl);
    do rdr(OFS_TCTL); while (r[0] !== 1'b0);
    repeat (40) @(posedge clk);
    chk(i_phy.txq.size(), 16 + 2 * ex.size());
    for (int k = 0; k < 15; k++) chk(i_phy.txq[k], 4'h5);
    chk(i_phy.txq[15], 4'hD);
    foreach (ex[i]) chk({i_phy.txq[17+2*i], i_phy.txq[16+2*i]}, ex[i]);
  endtask

  task automatic rx_run(input logic [7:0] q[$]);
    i_phy.rx_send(q);
    repeat (20) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({30'h0, ind_b, ind_a}, 32'h0000_0000);
    rdc(OFS_TCTL, 32'h0000_0006);
    rdc(OFS_RCTL, 32'h0000_0002);
    rdc(OFS_RIS, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    wrr(OFS_LED, 32'h0000_000C);
    repeat (4) @(posedge clk);
    chk({30'h0, ind_b, ind_a}, 32'h0000_0003);
    rdc(OFS_LED, 32'h0000_000C);
    wrr(OFS_LED, 32'h0000_0003);
    f = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B,
          8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h00, 8'h02, 8'hD5, 8'h55};
    b = f;
    b.push_front(8'h00);
    b.push_front(8'h02);
    g = f;
    repeat (44) g.push_back(8'h00);
    add_fcs(g);
    tx_run(32'h0000_0007, b, g);
    g = f;
    for (int i = 1; i < 5; i++) g.push_back(8'(i * 17));
    b = g;
    b.push_front(8'h00);
    b.push_front(8'h02);
    tx_run(32'h0000_0001, b, g);
    wrr(OFS_RCTL, 32'h0000_0003);
    f = '{8'h03, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h31, 8'h32, 8'h33,
          8'h34, 8'h35, 8'h36, 8'h05, 8'hDD, 8'h55, 8'hD5, 8'h00, 8'hFF};
    add_fcs(f);
    rx_run(f);
    rdc(OFS_RXCNT, 32'h0000_0001);
    rdc(OFS_RXLT, 32'h0003_05DD);
    b = f;
    b.push_front(8'h00);
    b.push_front(8'h16);
    for (int i = 0; i < b.size(); i += 4) rdc(OFS_RXD, {b[i+3], b[i+2], b[i+1], b[i]});
    wrr(OFS_RXCNT, 32'h0000_0000);
    rdc(OFS_RXCNT, 32'h0000_0000);
    f[21] = ~f[21];
    rx_run(f);
    rdc(OFS_RXCNT, 32'h0000_0000);
    rdc(OFS_RIS, 32'h0000_0002);
    wrr(OFS_RIS, 32'h0000_0002);
    rdc(OFS_RIS, 32'h0000_0000);
    wrr(OFS_RCTL, 32'h0000_0001);
    f[13] = 8'hDC;
    rx_run(f);
    rdc(OFS_RXCNT, 32'h0000_0001);
    rdc(OFS_RXLT, 32'h0002_05DC);
    wrr(OFS_RXCNT, 32'h0000_0000);
    f.delete();
    for (int i = 0; i < 2100; i++) f.push_back(8'(i));
    rx_run(f);
    rdc(OFS_RIS, 32'h0000_0001);
    rdc(OFS_RXCNT, 32'h0000_0000);
    tally_and_finish();
  end
endmodule

bind ethm_mac_test ethm_mac_checker i_chk (
  .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
  .i_rd(rd), .o_rdata(rdata), .i_mii_tx_clk(tx_clk), .o_mii_txd(txd),
  .o_mii_tx_en(tx_en), .o_activity_indicator_a(ind_a));
